// File: orient_pkg.sv
// Constants, codes and lookups shared by the orientation detect block.
// Assumes an external serial front end turns host transfers into single-cycle
// register strobes on an 8-bit address.
//
// Notes on behaviour
// - Config bit 7 selects the debounce mode (reset 1) and bit 6 enables detection (reset 0).
// - With mode 0 the counter steps down on a sample where the new state no longer holds, with mode 1 it clears.
// - Detection runs only while the enable bit is 1 and is idle while it is 0.
// - A read/write 8-bit debounce count at offset 0x12 resets to zero and sets the samples needed.
// - The least debounce latency equals the programmed count times the time step.
// - Any change between wake and sleep resets the internal debounce counter.
// - Each debounce count weighs one time step chosen by data rate and oversampling mode.
// - The fixed back/front trip angle code 01 reads in bits 7:6 of the read-only angle register.
// - The fixed z-tilt lockout code 100 reads in bits 2:0 of the same register.
// - The fixed portrait/landscape threshold code 1_0000 reads in bits 7:3 of the threshold register.
// - The fixed hysteresis code 100 reads in bits 2:0 of the threshold register.
// - Landscape turns to portrait at 59 degrees and portrait to landscape at 31 degrees.
// - The change flag sets on the first detection after going active and on any status change, and clears on a status read.
// - Orientation codes are 00 portrait up, 01 portrait down, 10 landscape right, 11 landscape left.
// - Orientation holds while any axis magnitude exceeds 1.25g.
package orient_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CFG = 8'h11;
    localparam logic [7:0] ADDR_COUNT = 8'h12;
    localparam logic [7:0] ADDR_BF_Z_TILT_LOCK_ANGLE = 8'h13;
    localparam logic [7:0] ADDR_THS_HYS = 8'h14;

    localparam int CFG_MODE_BIT = 7;
    localparam int CFG_EN_BIT = 6;
    localparam logic CFG_MODE_RST = 1'b1;
    localparam logic CFG_EN_RST = 1'b0;
    localparam logic [7:0] COUNT_RST = 8'h00;

    localparam int ST_FLAG_BIT = 7;
    localparam int ST_LOCK_BIT = 6;
    localparam int ST_CODE_LSB = 1;
    localparam int ST_BACK_BIT = 0;

    localparam logic [1:0] BACK_FRONT_TRIP_ANGLE_CODE = 2'h1;
    localparam logic [2:0] Z_TILT_LOCK_ANGLE_CODE = 3'h4;
    localparam logic [4:0] THS_CODE = 5'h10;
    localparam logic [2:0] HYS_CODE = 3'h4;
    localparam logic [7:0] BF_Z_TILT_LOCK_ANGLE_VALUE = {BACK_FRONT_TRIP_ANGLE_CODE, 3'h0, Z_TILT_LOCK_ANGLE_CODE};
    localparam logic [7:0] THS_HYS_VALUE = {THS_CODE, HYS_CODE};

    // ------------------------------------------------------------------
    // orientation codes and angle ratios (tangents in Q7)
    // ------------------------------------------------------------------
    localparam logic [1:0] ORIENT_PORT_UP = 2'h0;
    localparam logic [1:0] ORIENT_PORT_DOWN = 2'h1;
    localparam logic [1:0] ORIENT_LAND_RIGHT = 2'h2;
    localparam logic [1:0] ORIENT_LAND_LEFT = 2'h3;
    localparam int TAN_Q = 7;
    localparam logic [7:0] TAN_31_Q7 = 8'h4D;
    localparam logic [7:0] TAN_59_Q7 = 8'hD5;
    localparam logic [7:0] TAN_29_Q7 = 8'h47;
    localparam logic [7:0] TAN_15_Q7 = 8'h22;
    // 1.25g at 1024 counts per g
    localparam int HIGH_G_1P25 = 1280;

    // ------------------------------------------------------------------
    // data rate, oversampling and time step (unit 250 us)
    // ------------------------------------------------------------------
    localparam logic [1:0] OSR_NORMAL = 2'h0;
    localparam logic [1:0] OSR_LOW_NOISE_LOW_POWER_MODE = 2'h1;
    localparam logic [1:0] OSR_HIRES = 2'h2;
    localparam logic [1:0] OSR_LP = 2'h3;
    localparam int STEP_UNIT_US = 250;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_FIRST = 3'b010,
        ST_RUN = 3'b100
    } det_state_e;

    // odr 0..7 = 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
    function automatic logic [9:0] step_units(input logic [2:0] output_data_rate, input logic [1:0] osr);
        logic [9:0] s;
        s = 10'h0A;
        case (output_data_rate)
            3'h0: s = 10'h005;
            3'h1: s = 10'h00A;
            3'h2: s = (osr == OSR_HIRES) ? 10'h00A : 10'h014;
            3'h3: s = (osr == OSR_HIRES) ? 10'h00A : 10'h028;
            3'h4: s = (osr == OSR_HIRES) ? 10'h00A : 10'h050;
            3'h5: s = (osr == OSR_HIRES) ? 10'h00A : (osr == OSR_NORMAL) ? 10'h050 : 10'h140;
            default: begin
                case (osr)
                    OSR_NORMAL: s = 10'h050;
                    OSR_LOW_NOISE_LOW_POWER_MODE: s = 10'h140;
                    OSR_HIRES: s = 10'h00A;
                    default: s = 10'h280;
                endcase
            end
        endcase
        return s;
    endfunction : step_units

endpackage : orient_pkg

// File: orient_classify.sv
// Angle classifier: turns one accelerometer sample into candidate orientation.
// Assumes signed two's complement axis samples, 1024 counts per g by default.
`timescale 1ns/10ps
module orient_classify #(
    parameter int AW = 12,
    parameter int HIGH_G = orient_pkg::HIGH_G_1P25
) (
    // sample
    input wire logic signed [AW-1:0] accel_x_i,
    input wire logic signed [AW-1:0] accel_y_i,
    input wire logic signed [AW-1:0] accel_z_i,
    input wire logic cur_portrait_i,
    input wire logic [1:0] cur_code_i,
    // candidate
    output logic [1:0] cand_code_o,
    output logic cand_back_o,
    output logic cand_lock_o,
    output logic high_g_o
);
    if (AW < 8 || AW > 24) begin : g_bad_aw
        $error("orient_classify: AW out of range");
    end

    localparam int PW = AW + 8;

    function automatic logic [AW-1:0] mag(input logic signed [AW-1:0] a);
        return a[AW-1] ? AW'(-a) : AW'(a);
    endfunction : mag

    // a*2^7 > b*tan, both sides kept at PW bits
    function automatic logic ratio_gt(input logic [AW-1:0] a, input logic [AW-1:0] b,
                                      input logic [7:0] tan_q7);
        logic [PW-1:0] lhs;
        logic [PW-1:0] rhs;
        lhs = PW'(a) << orient_pkg::TAN_Q;
        rhs = PW'(b) * PW'(tan_q7);
        return lhs > rhs;
    endfunction : ratio_gt

    logic [AW-1:0] mx, my, mz, planar;
    logic portrait;

    always_comb begin
        mx = mag(accel_x_i);
        my = mag(accel_y_i);
        mz = mag(accel_z_i);
        planar = (mx > my) ? mx : my;
        // hysteresis: leave landscape above 59 deg, leave portrait below 31 deg
        if (cur_portrait_i) begin
            portrait = ratio_gt(my, mx, orient_pkg::TAN_31_Q7);
        end else begin
            portrait = ratio_gt(my, mx, orient_pkg::TAN_59_Q7);
        end
        cand_lock_o = ratio_gt(mz, planar, orient_pkg::TAN_29_Q7 ^ 8'h00) &&
                      !ratio_gt(planar, mz, orient_pkg::TAN_29_Q7);
        // back when gravity lies within 75 deg of -z
        cand_back_o = accel_z_i[AW-1] && ratio_gt(mz, planar, orient_pkg::TAN_15_Q7);
        if (cand_lock_o) begin
            cand_code_o = cur_code_i;
        end else if (portrait) begin
            cand_code_o = accel_y_i[AW-1] ? orient_pkg::ORIENT_PORT_UP
                                          : orient_pkg::ORIENT_PORT_DOWN;
        end else begin
            cand_code_o = accel_x_i[AW-1] ? orient_pkg::ORIENT_LAND_LEFT
                                          : orient_pkg::ORIENT_LAND_RIGHT;
        end
        high_g_o = (mx > AW'(HIGH_G)) || (my > AW'(HIGH_G)) || (mz > AW'(HIGH_G));
    end

endmodule : orient_classify

// File: orient_debounce.sv
// Debounce counter for orientation changes, one step per usable sample.
// Assumes sample_i is a one-cycle strobe per output data sample.
`timescale 1ns/10ps
module orient_debounce (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic clear_i,
    input wire logic sample_i,
    input wire logic differ_i,
    input wire logic mode_clear_i,
    input wire logic [7:0] count_i,
    // result
    output logic accept_o,
    output logic [7:0] cnt_o
);
    logic [7:0] cnt_ff, nxt_cnt;
    logic [8:0] inc;

    always_comb begin
        inc = {1'b0, cnt_ff} + 9'h001;
        nxt_cnt = cnt_ff;
        accept_o = 1'b0;
        if (clear_i) begin
            nxt_cnt = 8'h00;
        end else if (sample_i && differ_i) begin
            if (inc >= {1'b0, count_i}) begin
                accept_o = 1'b1;
                nxt_cnt = 8'h00;
            end else begin
                nxt_cnt = inc[7:0];
            end
        end else if (sample_i) begin
            if (mode_clear_i) begin
                nxt_cnt = 8'h00;
            end else if (cnt_ff != 8'h00) begin
                nxt_cnt = cnt_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign cnt_o = cnt_ff;

endmodule : orient_debounce

// File: orient_detect_top.sv
// Orientation detect block: config and status registers, debounce, change flag.
// Assumes a serial front end gives one-cycle read and write strobes, and that
// the sample strobe, power state and data rate come from the sensor core.
`timescale 1ns/10ps
module orient_detect_top #(
    parameter int AW = 12,
    parameter int HIGH_G = orient_pkg::HIGH_G_1P25
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // sensor samples
    input wire logic sample_i,
    input wire logic signed [AW-1:0] accel_x_i,
    input wire logic signed [AW-1:0] accel_y_i,
    input wire logic signed [AW-1:0] accel_z_i,
    // system state
    input wire logic active_i,
    input wire logic sleep_i,
    input wire logic [2:0] odr_sel_i,
    input wire logic [1:0] osr_mode_i,
    // results
    output logic orient_change_o,
    output logic [1:0] orient_code_o,
    output logic [9:0] time_step_o,
    output logic [17:0] debounce_latency_o
);
    if (HIGH_G < 1 || HIGH_G >= (1 << (AW - 1))) begin : g_bad_high_g
        $error("orient_detect_top: bad HIGH_G");
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic mode_sel_ff, nxt_mode_sel;
    logic detect_en_ff, nxt_detect_en;
    logic [7:0] count_ff, nxt_count;

    always_comb begin
        nxt_mode_sel = mode_sel_ff;
        nxt_detect_en = detect_en_ff;
        nxt_count = count_ff;
        if (reg_wr_i && reg_addr_i == orient_pkg::ADDR_CFG) begin
            nxt_mode_sel = reg_wdata_i[orient_pkg::CFG_MODE_BIT];
            nxt_detect_en = reg_wdata_i[orient_pkg::CFG_EN_BIT];
        end
        if (reg_wr_i && reg_addr_i == orient_pkg::ADDR_COUNT) begin
            nxt_count = reg_wdata_i;
        end
        // writes to the fixed angle registers fall through untouched
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_sel_ff <= orient_pkg::CFG_MODE_RST;
            detect_en_ff <= orient_pkg::CFG_EN_RST;
            count_ff <= orient_pkg::COUNT_RST;
        end else begin
            mode_sel_ff <= nxt_mode_sel;
            detect_en_ff <= nxt_detect_en;
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------------
    // classification and debounce
    // ------------------------------------------------------------------
    logic [1:0] code_ff, nxt_code;
    logic back_ff, nxt_back;
    logic lock_ff, nxt_lock;
    logic flag_ff, nxt_flag;
    logic [1:0] cand_code;
    logic cand_back, cand_lock, high_g;
    logic detecting, usable, differ, sleep_chg, db_clear, accept, first_take;
    logic status_rd, flag_set;
    logic [7:0] db_cnt;
    logic sleep_d_ff;
    orient_pkg::det_state_e state_ff, nxt_state;

    orient_classify #(
        .AW(AW),
        .HIGH_G(HIGH_G)
    ) u_classify (
        .accel_x_i(accel_x_i),
        .accel_y_i(accel_y_i),
        .accel_z_i(accel_z_i),
        .cur_portrait_i(!code_ff[1]),
        .cur_code_i(code_ff),
        .cand_code_o(cand_code),
        .cand_back_o(cand_back),
        .cand_lock_o(cand_lock),
        .high_g_o(high_g)
    );

    always_comb begin
        detecting = detect_en_ff && active_i;
        sleep_chg = sleep_i != sleep_d_ff;
        // high-g samples are not counted, so the orientation stays put
        usable = detecting && sample_i && !high_g && (state_ff == orient_pkg::ST_RUN);
        differ = {cand_code, cand_back, cand_lock} != {code_ff, back_ff, lock_ff};
        db_clear = sleep_chg || (state_ff != orient_pkg::ST_RUN) || !detecting;
        first_take = detecting && sample_i && !high_g && (state_ff == orient_pkg::ST_FIRST);
    end

    orient_debounce u_debounce (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(db_clear),
        .sample_i(usable),
        .differ_i(differ),
        .mode_clear_i(mode_sel_ff),
        .count_i(count_ff),
        .accept_o(accept),
        .cnt_o(db_cnt)
    );

    // ------------------------------------------------------------------
    // detection state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (!detecting) begin
            nxt_state = orient_pkg::ST_OFF;
        end else begin
            case (state_ff)
                orient_pkg::ST_OFF: nxt_state = orient_pkg::ST_FIRST;
                orient_pkg::ST_FIRST: begin
                    if (first_take) begin
                        nxt_state = orient_pkg::ST_RUN;
                    end
                end
                orient_pkg::ST_RUN: nxt_state = orient_pkg::ST_RUN;
                default: nxt_state = orient_pkg::ST_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status and change flag
    // ------------------------------------------------------------------
    always_comb begin
        status_rd = reg_rd_i && reg_addr_i == orient_pkg::ADDR_STATUS;
        flag_set = first_take || accept;
        nxt_code = code_ff;
        nxt_back = back_ff;
        nxt_lock = lock_ff;
        if (flag_set) begin
            nxt_code = cand_code;
            nxt_back = cand_back;
            nxt_lock = cand_lock;
        end
        // a change landing on the clearing read still wins
        if (flag_set) begin
            nxt_flag = 1'b1;
        end else if (status_rd) begin
            nxt_flag = 1'b0;
        end else begin
            nxt_flag = flag_ff;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= orient_pkg::ST_OFF;
            code_ff <= orient_pkg::ORIENT_PORT_UP;
            back_ff <= 1'b0;
            lock_ff <= 1'b0;
            flag_ff <= 1'b0;
            sleep_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            code_ff <= nxt_code;
            back_ff <= nxt_back;
            lock_ff <= nxt_lock;
            flag_ff <= nxt_flag;
            sleep_d_ff <= sleep_i;
        end
    end

    // ------------------------------------------------------------------
    // read data, time step and latency
    // ------------------------------------------------------------------
    logic [7:0] rdata_ff, nxt_rdata;
    logic [9:0] step_ff, nxt_step;
    logic [17:0] latency_ff, nxt_latency;

    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd_i) begin
            case (reg_addr_i)
                orient_pkg::ADDR_STATUS: begin
                    nxt_rdata = 8'h00;
                    nxt_rdata[orient_pkg::ST_FLAG_BIT] = flag_ff;
                    nxt_rdata[orient_pkg::ST_LOCK_BIT] = lock_ff;
                    nxt_rdata[orient_pkg::ST_CODE_LSB +: 2] = code_ff;
                    nxt_rdata[orient_pkg::ST_BACK_BIT] = back_ff;
                end
                orient_pkg::ADDR_CFG: begin
                    nxt_rdata = 8'h00;
                    nxt_rdata[orient_pkg::CFG_MODE_BIT] = mode_sel_ff;
                    nxt_rdata[orient_pkg::CFG_EN_BIT] = detect_en_ff;
                end
                orient_pkg::ADDR_COUNT: nxt_rdata = count_ff;
                orient_pkg::ADDR_BF_Z_TILT_LOCK_ANGLE: nxt_rdata = orient_pkg::BF_Z_TILT_LOCK_ANGLE_VALUE;
                orient_pkg::ADDR_THS_HYS: nxt_rdata = orient_pkg::THS_HYS_VALUE;
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_step = orient_pkg::step_units(odr_sel_i, osr_mode_i);
        // one cycle behind the step; fine for a slowly changing setting
        nxt_latency = 18'(count_ff) * 18'(step_ff);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= 8'h00;
            step_ff <= 10'h005;
            latency_ff <= 18'h00000;
        end else begin
            rdata_ff <= nxt_rdata;
            step_ff <= nxt_step;
            latency_ff <= nxt_latency;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign orient_change_o = flag_ff;
    assign orient_code_o = code_ff;
    assign time_step_o = step_ff;
    assign debounce_latency_o = latency_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_status_read;
        reg_rd_i && reg_addr_i == orient_pkg::ADDR_STATUS && !flag_set;
    endsequence

    sequence s_read_at(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence

    a_disabled_idle: assert property (!detect_en_ff |-> !accept && !first_take)
        else $error("orientation updated while disabled");

    a_flag_read_clear: assert property (s_status_read |=> !flag_ff)
        else $error("change flag not cleared by status read");

    a_flag_on_change: assert property (accept |=> flag_ff && code_ff == $past(cand_code))
        else $error("accepted change did not raise flag");

    a_angle_fixed: assert property (s_read_at(orient_pkg::ADDR_BF_Z_TILT_LOCK_ANGLE) |=>
        reg_rdata_o == 8'h44)
        else $error("angle register value wrong");

    a_thresh_fixed: assert property (s_read_at(orient_pkg::ADDR_THS_HYS) |=>
        reg_rdata_o == 8'h84)
        else $error("threshold register value wrong");

    a_high_g_hold: assert property (high_g |=> $stable(code_ff) && $stable(back_ff))
        else $error("orientation moved during high-g");

    a_sleep_reset: assert property ($changed(sleep_i) |=> db_cnt == 8'h00)
        else $error("power state change kept debounce count");

    a_mode_clear: assert property (usable && !differ && !db_clear && mode_sel_ff |=>
        db_cnt == 8'h00)
        else $error("clear mode did not clear counter");

    a_mode_decr: assert property (usable && !differ && !db_clear && !mode_sel_ff &&
        db_cnt != 8'h00 |=> db_cnt == $past(db_cnt) - 8'h01)
        else $error("decrement mode did not step down");

    a_accept_count: assert property (accept |-> {1'b0, db_cnt} + 9'h001 >= {1'b0, count_ff})
        else $error("accepted before count reached");

    a_step_fast: assert property (odr_sel_i == 3'h0 |=> time_step_o == 10'h005)
        else $error("800 Hz step wrong");

    a_cfg_write: assert property (reg_wr_i && reg_addr_i == orient_pkg::ADDR_CFG |=>
        detect_en_ff == $past(reg_wdata_i[6]) && mode_sel_ff == $past(reg_wdata_i[7]))
        else $error("config write not stored");

    a_first_flag: assert property (first_take |=> flag_ff)
        else $error("first detection did not raise flag");

    a_idle_off: assert property (!detecting |=> state_ff == orient_pkg::ST_OFF)
        else $error("detection state kept while idle");

    a_count_write: assert property (reg_wr_i && reg_addr_i == orient_pkg::ADDR_COUNT |=>
        count_ff == $past(reg_wdata_i))
        else $error("debounce count write not stored");

endmodule : orient_detect_top

// File: host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes the bench calls its tasks and drives nothing else on this port.
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // strobes last one cycle and move only on falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        // stale data must not look valid after the strobe
        reg_wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : host_model

// File: orientation_detect_config_tb.sv
// Self-checking bench for the orientation detect block.
// Assumes host_model drives the register port; samples are driven here.
`timescale 1ns/10ps
module orientation_detect_config_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, chg;
    logic sample_i = 1'b0, active_i = 1'b1, sleep_i = 1'b0;
    logic signed [11:0] ax = 12'h000, ay = 12'h000, az = 12'h000;
    logic [2:0] output_data_rate = 3'h0;
    logic [1:0] osr = 2'h0, code;
    logic [9:0] step;
    logic [17:0] lat;
    int n_mismatch = 0, n_compared = 0, seed = 32'h74f9, cycles = 0;
    localparam logic [11:0] P = 12'h320, N = 12'hCE0, H = 12'h5DC, M = 12'h258, Z = 12'h000;

    always #4 clk_i = ~clk_i;

    host_model i_host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

    orient_detect_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .sample_i(sample_i), .accel_x_i(ax), .accel_y_i(ay),
        .accel_z_i(az), .active_i(active_i), .sleep_i(sleep_i), .odr_sel_i(output_data_rate),
        .osr_mode_i(osr), .orient_change_o(chg), .orient_code_o(code),
        .time_step_o(step), .debounce_latency_o(lat));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_host.rd(a, v);
        chk(18'(v), 18'(e));
    endtask : rchk

    task automatic cc(input logic [1:0] e);
        chk(18'(code), 18'(e));
    endtask : cc

    task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(negedge clk_i);
        ax = x;
        ay = y;
        az = z;
        sample_i = 1'b1;
        @(negedge clk_i);
        sample_i = 1'b0;
        ax = ~x;
        @(negedge clk_i);
    endtask : smp

    // step in 250 us units
    function automatic logic [9:0] step_exp(input int o, input int m);
        logic [9:0] s;
        s = 10'h005 << o;
        if (o > 4) s = 10'h050;
        if (o > 4 && m != 0) s = 10'h140;
        if (o > 5 && m == 3) s = 10'h280;
        if (o > 1 && m == 2) s = 10'h00A;
        return s;
    endfunction : step_exp

    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // a full run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        rchk(orient_pkg::ADDR_CFG, 8'h80);
        rchk(orient_pkg::ADDR_COUNT, 8'h00);
        rchk(orient_pkg::ADDR_BF_Z_TILT_LOCK_ANGLE, 8'h44);
        rchk(orient_pkg::ADDR_THS_HYS, 8'h84);
        repeat (4) begin
            d = 8'($random(seed));
            i_host.wr(orient_pkg::ADDR_COUNT, d);
            rchk(orient_pkg::ADDR_COUNT, d);
        end
        i_host.wr(orient_pkg::ADDR_BF_Z_TILT_LOCK_ANGLE, d);
        i_host.wr(orient_pkg::ADDR_THS_HYS, ~d);
        rchk(orient_pkg::ADDR_BF_Z_TILT_LOCK_ANGLE, 8'h44);
        rchk(orient_pkg::ADDR_THS_HYS, 8'h84);
        i_host.wr(orient_pkg::ADDR_CFG, 8'hFF);
        rchk(orient_pkg::ADDR_CFG, 8'hC0);
        rchk(8'h3F, 8'h00);
        for (int o = 0; o < 8; o++) begin
            for (int m = 0; m < 4; m++) begin
                output_data_rate = 3'(o);
                osr = 2'(m);
                repeat (3) @(negedge clk_i);
                chk(18'(step), 18'(step_exp(o, m)));
                chk(lat, 18'(d) * 18'(step_exp(o, m)));
            end
        end
        // standby then active, first detection sets the flag
        active_i = 1'b0;
        repeat (2) @(negedge clk_i);
        active_i = 1'b1;
        repeat (3) @(negedge clk_i);
        smp(Z, P, Z);
        chk(18'(chg), 18'h1);
        cc(2'h1);
        rchk(orient_pkg::ADDR_STATUS, 8'h82);
        chk(18'(chg), 18'h0);
        i_host.wr(orient_pkg::ADDR_COUNT, 8'h02);
        smp(Z, N, Z);
        smp(Z, P, Z);
        smp(Z, N, Z);
        cc(2'h1);
        smp(Z, N, Z);
        cc(2'h0);
        i_host.wr(orient_pkg::ADDR_CFG, 8'h40);
        i_host.wr(orient_pkg::ADDR_COUNT, 8'h03);
        smp(N, Z, Z);
        smp(N, Z, Z);
        smp(Z, N, Z);
        smp(N, Z, Z);
        cc(2'h0);
        smp(N, Z, Z);
        cc(2'h3);
        i_host.wr(orient_pkg::ADDR_COUNT, 8'h00);
        smp(P, Z, H);
        cc(2'h3);
        smp(M, P, Z);
        cc(2'h2);
        i_host.wr(orient_pkg::ADDR_COUNT, 8'h02);
        smp(Z, P, Z);
        sleep_i = 1'b1;
        smp(Z, P, Z);
        cc(2'h2);
        smp(Z, P, Z);
        cc(2'h1);
        smp(M, N, Z);
        smp(M, N, Z);
        cc(2'h0);
        rchk(orient_pkg::ADDR_STATUS, 8'h80);
        // face down and flat: lockout keeps the code, back and lockout flags rise
        smp(Z, Z, N);
        smp(Z, Z, N);
        rchk(orient_pkg::ADDR_STATUS, 8'hC1);
        i_host.wr(orient_pkg::ADDR_CFG, 8'h80);
        smp(Z, P, Z);
        smp(Z, P, Z);
        cc(2'h0);
        report_and_stop();
    end
endmodule : orientation_detect_config_tb
